//--- rtl/list_sweep_pkg.sv
// Shared constants, encodings and carrier types of the list sweep sequencer.
// How it works
// - Trigger select 0 is external pin, 1 is bus trigger, 2 is immediate.
// - Continuous mode runs all points then restarts at the first, forever.
// - Single sweep runs all points once, halts; next trigger restarts at first.
// - Single step runs one point, halts; each trigger advances one point.
// - Point pointer starts at the first point and wraps after the last.
// - Selecting a list only starts it when repeat mode is continuous and trigger select is immediate.
// - Active point query returns the index of the point now active.
// - Trigger select is immediate after reset or presets.
// - Point N+1 is compiled while point N is output.
// - Compiling one point takes about 25 ms.
// - If the next point is not compiled at dwell end, pause until it is.
// - With retrace output-off, output is blanked during a compile pause.
// - Step triggers arriving during a compile pause may be lost.
// - Precompile compiles every point of a list, then answers 2.
// - Precompile of an already compiled list answers promptly.
// - Source points live in nonvolatile storage that survives power cycles.
// - Object points live in volatile storage lost at power-off.
// - Edits, precompiles and uncompiled runs allocate object points.
// - Object points are freed only by clearing a list or power cycle.
// - Source points are freed by remove, clear, presets or storage clear.
// - External trigger holds until a pin pulse, then starts at first point.
// - Immediate trigger is rejected while repeat mode is single step.
package list_sweep_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam logic [3:0] REG_TRIG_SRC   = 4'h0;
   localparam logic [3:0] REG_REPEAT     = 4'h1;
   localparam logic [3:0] REG_SELECT     = 4'h2;
   localparam logic [3:0] REG_PRECOMPILE = 4'h3;
   localparam logic [3:0] REG_ACTIVE_PT  = 4'h4;
   localparam logic [3:0] REG_CLEAR      = 4'h5;
   localparam logic [3:0] REG_APPEND     = 4'h6;
   localparam logic [3:0] REG_REMOVE     = 4'h7;
   localparam logic [3:0] REG_EDIT_SEL   = 4'h8;
   localparam logic [3:0] REG_FREQ       = 4'h9;
   localparam logic [3:0] REG_LEVEL      = 4'ha;
   localparam logic [3:0] REG_DWELL      = 4'hb;
   localparam logic [3:0] REG_PRESET     = 4'hc;
   localparam logic [3:0] REG_BUS_TRIG   = 4'hd;
   localparam logic [3:0] REG_CONFIG     = 4'he;
   localparam logic [3:0] REG_STATUS     = 4'hf;
   localparam logic [1:0] TRIG_EXT = 2'h0;
   localparam logic [1:0] TRIG_BUS = 2'h1;
   localparam logic [1:0] TRIG_IMM = 2'h2;
   localparam logic [2:0] RPT_CONT  = 3'h0;
   localparam logic [2:0] RPT_SWEEP = 3'h2;
   localparam logic [2:0] RPT_STEP  = 3'h4;
   localparam logic [1:0] TRIG_RST = TRIG_IMM;
   localparam logic [2:0] RPT_RST  = RPT_CONT;
   localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
   localparam int unsigned COMPILE_TIME_MS = 25;
   localparam int unsigned COMPILE_CYC = COMPILE_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int unsigned DWELL_UNIT_US  = 1;
   localparam int unsigned DWELL_TICK_CYC =
      DWELL_UNIT_US * (CLK_FREQ_HZ / 1_000_000);
   localparam logic [11:0] OBJ_POOL_LIMIT = 12'h3e8;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ARMED = 3'b001,
      ST_PAUSE = 3'b010,
      ST_DWELL = 3'b011,
      ST_HOLD  = 3'b100
   } seq_state_e;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_s;
   typedef struct packed {
      logic [15:0] freq;
      logic [7:0]  level;
      logic        on;
   } rf_out_s;
endpackage

//--- rtl/list_sweep_sequencer.sv
// List sweep sequencer: list storage, point compiler and execution engine.
`timescale 1ns/100ps
module list_sweep_sequencer #(
   parameter int unsigned LISTS          = 4,
   parameter int unsigned POINTS         = 8,
   parameter int unsigned COMPILE_CYCLES = list_sweep_pkg::COMPILE_CYC
) (
   // Clock and resets
   input  wire logic                      sys_clk,
   input  wire logic                      reset_n,
   input  wire logic                      nv_init_n,
   // Register port
   input  list_sweep_pkg::reg_req_s       bus_req,
   output logic [15:0]                    rd_data,
   // External trigger pin
   input  wire logic                      ext_trig_in,
   // Signal generator drive
   output list_sweep_pkg::rf_out_s        rf_out,
   output logic                           seq_running
);
   import list_sweep_pkg::*;

   localparam int unsigned LW  = (LISTS > 1) ? $clog2(LISTS) : 1;
   localparam int unsigned PW  = (POINTS > 1) ? $clog2(POINTS) : 1;
   localparam int unsigned CW  = $clog2(POINTS + 1);
   localparam int unsigned CCW = $clog2(COMPILE_CYCLES + 1);
   localparam logic [CCW-1:0] CMP_LAST = CCW'(COMPILE_CYCLES - 1);
   localparam logic [6:0] TICK_LAST = 7'(DWELL_TICK_CYC - 1);
   localparam logic [CW-1:0] LEN_MAX = CW'(POINTS);

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [LISTS-1:0][POINTS-1:0][15:0] freq;
      logic [LISTS-1:0][POINTS-1:0][7:0]  level;
      logic [LISTS-1:0][POINTS-1:0][15:0] dwell;
      logic [LISTS-1:0][CW-1:0]           len;
      logic [11:0]                        used;
   } nv_s;

   typedef struct packed {
      logic                                trig_s1;
      logic                                trig_s2;
      logic                                trig_s3;
      logic [1:0]                          trig_src;
      logic [2:0]                          rpt;
      logic                                retrace_off;
      logic                                trig_err;
      logic [LW-1:0]                       cur_list;
      logic [PW-1:0]                       pt;
      seq_state_e                          st;
      logic [15:0]                         dwell_cnt;
      logic [6:0]                          tick;
      logic                                cmp_busy;
      logic [LW-1:0]                       cmp_list;
      logic [PW-1:0]                       cmp_pt;
      logic [CCW-1:0]                      cmp_cnt;
      logic                                pre_busy;
      logic                                pre_done;
      logic [LW-1:0]                       pre_list;
      logic [CW-1:0]                       pre_pt;
      logic [LISTS-1:0][POINTS-1:0]        obj_ok;
      logic [LISTS-1:0][POINTS-1:0][39:0]  obj;
      logic [LISTS-1:0][11:0]              obj_alloc;
      logic [11:0]                         obj_used;
      logic [LW-1:0]                       ed_list;
      logic [PW-1:0]                       ed_pt;
      logic [15:0]                         rd_data;
      rf_out_s                             rf;
      logic                                running;
   } state_s;

   localparam state_s RST_STATE = '{st: ST_IDLE, trig_src: TRIG_RST,
                                    rpt: RPT_RST, default: '0};

   state_s     st_q;
   state_s     s;
   nv_s        nv_q;
   nv_s        nv;
   logic       wr;
   logic       rd;
   logic [3:0] a;
   logic [LW-1:0] w_list;
   logic [CW-1:0] len_c;
   logic [CW-1:0] pre_len;
   logic       last_pt;
   logic [PW-1:0] nxt_pt;
   logic       cur_ok;
   logic       trig_edge;
   logic       trig_hit;
   logic       expire;
   logic [PW-1:0] rt_tgt;
   logic       rt_need;

   assign wr      = bus_req.wr;
   assign rd      = bus_req.rd;
   assign a       = bus_req.addr;
   assign w_list  = bus_req.wdata[LW-1:0];
   assign len_c   = nv_q.len[st_q.cur_list];
   assign pre_len = nv_q.len[st_q.pre_list];
   assign last_pt = (CW'(st_q.pt) + 1'b1) >= len_c;
   assign nxt_pt  = last_pt ? '0 : PW'(st_q.pt + 1'b1);
   assign cur_ok  = st_q.obj_ok[st_q.cur_list][st_q.pt];
   assign trig_edge = st_q.trig_s2 & ~st_q.trig_s3;
   // Bus trigger works for any non-pin source so a sweep can be kicked off.
   assign trig_hit = (st_q.trig_src == TRIG_EXT) ? trig_edge
                   : (wr && a == REG_BUS_TRIG);
   assign expire  = (st_q.st == ST_DWELL) && (st_q.tick == TICK_LAST) &&
                    (st_q.dwell_cnt <= 16'h0001);
   assign rt_tgt  = (st_q.st == ST_PAUSE) ? st_q.pt : nxt_pt;
   assign rt_need = (st_q.st == ST_PAUSE || st_q.st == ST_DWELL ||
                     st_q.st == ST_HOLD) && len_c != '0 &&
                    !st_q.obj_ok[st_q.cur_list][rt_tgt];

   ////////////////////////////////////////////////////////////////////////
   // Source storage keeps its contents over reset_n, which models power.
   always_comb begin
      nv = nv_q;
      if (wr) begin
         case (a)
            REG_APPEND: begin
               if (nv.len[w_list] < LEN_MAX) begin
                  nv.len[w_list] = nv_q.len[w_list] + 1'b1;
                  nv.used = nv_q.used + 12'h001;
               end
            end
            REG_REMOVE: begin
               if (nv.len[w_list] != '0) begin
                  nv.len[w_list] = nv_q.len[w_list] - 1'b1;
                  nv.used = nv_q.used - 12'h001;
               end
            end
            REG_CLEAR: begin
               nv.used = nv_q.used - 12'(nv_q.len[w_list]);
               nv.len[w_list] = '0;
            end
            REG_PRESET: begin
               nv.len = '0;
               nv.used = '0;
            end
            REG_FREQ:  nv.freq[st_q.ed_list][st_q.ed_pt] = bus_req.wdata;
            REG_LEVEL: nv.level[st_q.ed_list][st_q.ed_pt] =
                          bus_req.wdata[7:0];
            REG_DWELL: nv.dwell[st_q.ed_list][st_q.ed_pt] = bus_req.wdata;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nv_init_n) begin
      if (!nv_init_n) begin
         nv_q <= '0;
      end else begin
         nv_q <= nv;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s = st_q;
      s.trig_s1 = ext_trig_in;
      s.trig_s2 = st_q.trig_s1;
      s.trig_s3 = st_q.trig_s2;
      s.rd_data = '0;

      // Execution engine.
      case (st_q.st)
         ST_IDLE: begin
            s.rf.on = 1'b0;
         end
         ST_ARMED: begin
            if (len_c != '0 && (trig_hit ||
                (st_q.trig_src == TRIG_IMM && st_q.rpt == RPT_CONT))) begin
               s.pt = '0;
               s.st = ST_PAUSE;
            end
         end
         ST_HOLD: begin
            // Triggers while paused are not queued, so steps may be missed.
            if (trig_hit) begin
               s.pt = (st_q.rpt == RPT_STEP) ? nxt_pt : '0;
               s.st = ST_PAUSE;
            end
         end
         ST_PAUSE: begin
            if (len_c == '0) begin
               s.st = ST_IDLE;
               s.rf.on = 1'b0;
            end else if (CW'(st_q.pt) >= len_c) begin
               s.pt = '0;
            end else if (cur_ok) begin
               s.rf.freq  = st_q.obj[st_q.cur_list][st_q.pt][39:24];
               s.rf.level = st_q.obj[st_q.cur_list][st_q.pt][23:16];
               s.rf.on    = 1'b1;
               s.dwell_cnt = st_q.obj[st_q.cur_list][st_q.pt][15:0];
               s.tick = '0;
               s.st = ST_DWELL;
            end else begin
               s.rf.on = ~st_q.retrace_off;
            end
         end
         ST_DWELL: begin
            if (st_q.tick == TICK_LAST) begin
               s.tick = '0;
               s.dwell_cnt = st_q.dwell_cnt - 16'h0001;
            end else begin
               s.tick = st_q.tick + 7'h01;
            end
            if (expire) begin
               case (st_q.rpt)
                  RPT_SWEEP: begin
                     s.st = last_pt ? ST_HOLD : ST_PAUSE;
                     s.pt = last_pt ? st_q.pt : nxt_pt;
                  end
                  RPT_STEP: s.st = ST_HOLD;
                  default: begin
                     s.st = ST_PAUSE;
                     s.pt = nxt_pt;
                  end
               endcase
            end
         end
         default: s.st = ST_IDLE;
      endcase

      // Point compiler, shared by look-ahead and precompilation.
      if (st_q.cmp_busy) begin
         if (st_q.cmp_cnt == CMP_LAST) begin
            s.cmp_busy = 1'b0;
            s.obj[st_q.cmp_list][st_q.cmp_pt] = {
               nv_q.freq[st_q.cmp_list][st_q.cmp_pt],
               nv_q.level[st_q.cmp_list][st_q.cmp_pt],
               nv_q.dwell[st_q.cmp_list][st_q.cmp_pt]};
            s.obj_ok[st_q.cmp_list][st_q.cmp_pt] = 1'b1;
            s.obj_alloc[st_q.cmp_list] = st_q.obj_alloc[st_q.cmp_list] +
                                         12'h001;
            s.obj_used = st_q.obj_used + 12'h001;
         end else begin
            s.cmp_cnt = st_q.cmp_cnt + 1'b1;
         end
      end else if (rt_need) begin
         s.cmp_busy = 1'b1;
         s.cmp_list = st_q.cur_list;
         s.cmp_pt   = rt_tgt;
         s.cmp_cnt  = '0;
      end else if (st_q.pre_busy) begin
         if (st_q.pre_pt >= pre_len) begin
            s.pre_busy = 1'b0;
            s.pre_done = 1'b1;
         end else if (st_q.obj_ok[st_q.pre_list][st_q.pre_pt[PW-1:0]]) begin
            s.pre_pt = st_q.pre_pt + 1'b1;
         end else begin
            s.cmp_busy = 1'b1;
            s.cmp_list = st_q.pre_list;
            s.cmp_pt   = st_q.pre_pt[PW-1:0];
            s.cmp_cnt  = '0;
         end
      end

      // Register reads; data stand in the following cycle.
      if (rd) begin
         case (a)
            REG_TRIG_SRC:   s.rd_data = {14'h0000, st_q.trig_src};
            REG_REPEAT:     s.rd_data = {13'h0000, st_q.rpt};
            REG_SELECT:     s.rd_data = 16'(st_q.cur_list);
            REG_PRECOMPILE: begin
               s.rd_data = {14'h0000, st_q.pre_done, st_q.pre_busy};
               s.pre_done = st_q.pre_busy && st_q.pre_pt >= pre_len &&
                            !st_q.cmp_busy && !rt_need;
            end
            REG_ACTIVE_PT:  s.rd_data = 16'(st_q.pt);
            REG_CLEAR:      s.rd_data = {4'h0, st_q.obj_used};
            REG_APPEND:     s.rd_data = {4'h0, nv_q.used};
            REG_EDIT_SEL:   s.rd_data = {8'(st_q.ed_list), 8'(st_q.ed_pt)};
            REG_CONFIG:     s.rd_data = {15'h0000, st_q.retrace_off};
            REG_STATUS: begin
               s.rd_data = {10'h000, st_q.obj_used > OBJ_POOL_LIMIT,
                            st_q.trig_err, st_q.cmp_busy, st_q.st};
               s.trig_err = 1'b0;
            end
            default:        s.rd_data = '0;
         endcase
      end

      // Register writes; commands take priority over the engine.
      if (wr) begin
         case (a)
            REG_TRIG_SRC: begin
               if (bus_req.wdata[1:0] == TRIG_IMM && st_q.rpt == RPT_STEP)
                  s.trig_err = 1'b1;
               else if (bus_req.wdata[1:0] <= TRIG_IMM)
                  s.trig_src = bus_req.wdata[1:0];
               else
                  s.trig_err = 1'b1;
            end
            REG_REPEAT: begin
               if (bus_req.wdata[2:0] == RPT_CONT ||
                   bus_req.wdata[2:0] == RPT_SWEEP ||
                   bus_req.wdata[2:0] == RPT_STEP)
                  s.rpt = bus_req.wdata[2:0];
               else
                  s.trig_err = 1'b1;
            end
            REG_SELECT: begin
               s.cur_list = w_list;
               s.pt = '0;
               s.st = ST_ARMED;
               s.rf.on = 1'b0;
            end
            REG_PRECOMPILE: begin
               s.pre_busy = 1'b1;
               s.pre_done = 1'b0;
               s.pre_list = w_list;
               s.pre_pt   = '0;
            end
            REG_CLEAR: begin
               s.obj_used = s.obj_used - st_q.obj_alloc[w_list];
               s.obj_alloc[w_list] = '0;
               s.obj_ok[w_list] = '0;
               if (st_q.cmp_busy && st_q.cmp_list == w_list)
                  s.cmp_busy = 1'b0;
            end
            REG_APPEND: begin
               if (nv_q.len[w_list] < LEN_MAX)
                  s.obj_ok[w_list][nv_q.len[w_list][PW-1:0]] = 1'b0;
            end
            REG_REMOVE: begin
               if (nv_q.len[w_list] != '0)
                  s.obj_ok[w_list][PW'(nv_q.len[w_list] - 1'b1)] = 1'b0;
            end
            REG_EDIT_SEL: begin
               s.ed_list = bus_req.wdata[8 +: LW];
               s.ed_pt   = bus_req.wdata[0 +: PW];
            end
            REG_FREQ, REG_LEVEL, REG_DWELL: begin
               // Stale object form is rebuilt by a later precompile or by the run-time compile.
               s.obj_ok[st_q.ed_list][st_q.ed_pt] = 1'b0;
               s.obj_alloc[st_q.ed_list] = s.obj_alloc[st_q.ed_list] +
                                           12'h001;
               s.obj_used = s.obj_used + 12'h001;
            end
            REG_PRESET: begin
               s.trig_src = TRIG_RST;
               s.rpt = RPT_RST;
               s.st = ST_IDLE;
               s.rf.on = 1'b0;
               s.obj_ok = '0;
               s.pre_busy = 1'b0;
               s.cmp_busy = 1'b0;
            end
            REG_CONFIG: s.retrace_off = bus_req.wdata[0];
            default: begin
            end
         endcase
      end
      s.running = (s.st == ST_PAUSE || s.st == ST_DWELL);
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= RST_STATE;
      end else begin
         st_q <= s;
      end
   end

   assign rd_data     = st_q.rd_data;
   assign rf_out      = st_q.rf;
   assign seq_running = st_q.running;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_expire_last;
      expire && last_pt && !wr;
   endsequence

   sequence s_ext_start;
      st_q.st == ST_ARMED && st_q.trig_src == TRIG_EXT &&
      trig_edge && len_c != '0 && !wr;
   endsequence

   chk_ext_start: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      s_ext_start |=> st_q.st == ST_PAUSE && st_q.pt == '0)
      else $error("external trigger did not start at first point");

   chk_cont_wrap: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      s_expire_last ##0 st_q.rpt == RPT_CONT
      |=> st_q.st == ST_PAUSE && st_q.pt == '0)
      else $error("continuous list did not wrap to first point");

   chk_sweep_halt: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      s_expire_last ##0 st_q.rpt == RPT_SWEEP
      |=> st_q.st == ST_HOLD ##1
          (st_q.st == ST_HOLD || $past(trig_hit) || $past(wr)))
      else $error("single sweep did not halt after last point");

   chk_step_hold: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      expire && !wr && st_q.rpt == RPT_STEP
      |=> st_q.st == ST_HOLD && $stable(st_q.pt))
      else $error("single step did not halt on its point");

   chk_step_next: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      st_q.st == ST_HOLD && st_q.rpt == RPT_STEP && trig_hit && !wr
      |=> st_q.pt == $past(nxt_pt))
      else $error("step trigger did not advance to next point");

   chk_select_only: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      wr && a == REG_SELECT && st_q.rpt != RPT_CONT
      ##1 (!trig_hit && !wr) |=> st_q.st == ST_ARMED)
      else $error("list select started a non-continuous list");

   chk_point_query: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      rd && a == REG_ACTIVE_PT |=> rd_data == 16'($past(st_q.pt)))
      else $error("active point query returned wrong index");

   chk_pause_blank: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      st_q.st == ST_PAUSE && !cur_ok && st_q.retrace_off && !wr &&
      len_c != '0 && CW'(st_q.pt) < len_c |=> !rf_out.on)
      else $error("output not blanked during compile pause");

   chk_compile_done: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      st_q.cmp_busy && st_q.cmp_cnt == CMP_LAST && !wr
      |=> !st_q.cmp_busy &&
          st_q.obj_ok[$past(st_q.cmp_list)][$past(st_q.cmp_pt)])
      else $error("compile did not finish on its last cycle");

   chk_imm_reject: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      wr && a == REG_TRIG_SRC && bus_req.wdata[1:0] == TRIG_IMM &&
      st_q.rpt == RPT_STEP |=> $stable(st_q.trig_src) && st_q.trig_err)
      else $error("immediate trigger accepted in single step");

   chk_dwell_load: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      st_q.st == ST_PAUSE && cur_ok && !wr && CW'(st_q.pt) < len_c
      |=> st_q.st == ST_DWELL && rf_out.on)
      else $error("dwell did not begin when point was ready");
endmodule

//--- verif/trig_host.sv
// External trigger source that pulses the sequencer's trigger pin.
`timescale 1ns/100ps
module trig_host (
   // Clock
   input  wire logic sys_clk,
   // Trigger pin, driven low between pulses
   output logic      ext_trig_in
);
   initial ext_trig_in = 1'b0;
   // The pulse outlasts the two-flop synchroniser on the pin.
   task automatic fire();
      @(posedge sys_clk);
      ext_trig_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ext_trig_in <= 1'b0;
   endtask
endmodule

//--- verif/test_list_sweep_sequencer.sv
// Self-checking bench of the list sweep sequencer.
`timescale 1ns/100ps
module test_list_sweep_sequencer;
   import list_sweep_pkg::*;
   logic        sys_clk, reset_n, nv_init_n, ext_trig_in, seq_running;
   reg_req_s    bus_req;
   rf_out_s     rf_out;
   logic [15:0] rd_data, q;
   int          n_fail = 0, n_tests = 0, cyc = 0;
   list_sweep_sequencer #(.COMPILE_CYCLES(20)) i_list_sweep_sequencer (
      .sys_clk(sys_clk), .reset_n(reset_n), .nv_init_n(nv_init_n),
      .bus_req(bus_req), .rd_data(rd_data), .ext_trig_in(ext_trig_in),
      .rf_out(rf_out), .seq_running(seq_running));
   trig_host i_trig_host (.sys_clk(sys_clk), .ext_trig_in(ext_trig_in));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   //////////////////////////////
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 q = rd_data;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Polls a register under a bounded count, then compares the field.
   task automatic poll(input logic [3:0] a, input logic [15:0] m, v);
      for (int k = 0; k < 300; k++) begin
         rd(a);
         if ((q & m) === v) break;
      end
      chk(q & m, v);
   endtask
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   //////////////////////////////
   task automatic test_codes();
      rd(REG_TRIG_SRC);
      chk(q, 16'h0002);
      @(posedge sys_clk);
      #1 chk(rd_data, 16'h0000);
      rd(REG_REMOVE);
      chk(q, 16'h0000);
      for (int t = 0; t < 2; t++) begin
         wr(REG_TRIG_SRC, 16'(t));
         rd(REG_TRIG_SRC);
         chk(q, 16'(t));
      end
      wr(REG_REPEAT, 16'h0004);
      wr(REG_TRIG_SRC, 16'h0002);
      rd(REG_TRIG_SRC);
      chk(q, 16'h0001);
      rd(REG_STATUS);
      chk(q & 16'h0010, 16'h0010);
      $display("test codes done");
   endtask
   task automatic test_precompile();
      wr(REG_APPEND, 16'h0001);
      wr(REG_APPEND, 16'h0001);
      for (int p = 0; p < 2; p++) begin
         wr(REG_EDIT_SEL, 16'h0100 | 16'(p));
         wr(REG_FREQ, 16'h1000 | 16'(p));
         wr(REG_LEVEL, 16'h0020 | 16'(p));
         wr(REG_DWELL, 16'h0001);
      end
      wr(REG_PRECOMPILE, 16'h0001);
      poll(REG_PRECOMPILE, 16'hffff, 16'h0002);
      wr(REG_PRECOMPILE, 16'h0001);
      rd(REG_STATUS);
      rd(REG_PRECOMPILE);
      chk(q, 16'h0002);
      $display("test precompile done");
   endtask
   task automatic test_step();
      wr(REG_TRIG_SRC, 16'h0000);
      wr(REG_SELECT, 16'h0001);
      rd(REG_STATUS);
      chk(q & 16'h0007, 16'h0001);
      for (int n = 0; n < 3; n++) begin
         i_trig_host.fire();
         poll(REG_STATUS, 16'h0007, 16'h0003);
         chk(rf_out.freq, 16'h1000 | 16'(n % 2));
         chk(rf_out.level, 16'h0020 | 16'(n % 2));
         chk(rf_out.on, 1'b1);
         chk(seq_running, 1'b1);
         poll(REG_STATUS, 16'h0007, 16'h0004);
         chk(seq_running, 1'b0);
         rd(REG_ACTIVE_PT);
         chk(q, 16'(n % 2));
      end
      $display("test step done");
   endtask
   task automatic test_cont();
      wr(REG_REPEAT, 16'h0000);
      wr(REG_TRIG_SRC, 16'h0002);
      wr(REG_SELECT, 16'h0001);
      poll(REG_ACTIVE_PT, 16'hffff, 16'h0001);
      poll(REG_ACTIVE_PT, 16'hffff, 16'h0000);
      $display("test continuous done");
   endtask
   task automatic test_sweep();
      wr(REG_REPEAT, 16'h0002);
      wr(REG_TRIG_SRC, 16'h0001);
      wr(REG_SELECT, 16'h0001);
      rd(REG_STATUS);
      chk(q & 16'h0007, 16'h0001);
      wr(REG_BUS_TRIG, 16'h0000);
      poll(REG_STATUS, 16'h0007, 16'h0004);
      rd(REG_ACTIVE_PT);
      chk(q, 16'h0001);
      wr(REG_BUS_TRIG, 16'h0000);
      rd(REG_ACTIVE_PT);
      chk(q, 16'h0000);
      $display("test sweep done");
   endtask
   task automatic test_pause();
      wr(REG_CONFIG, 16'h0001);
      wr(REG_EDIT_SEL, 16'h0100);
      wr(REG_FREQ, 16'h2000);
      wr(REG_REPEAT, 16'h0000);
      wr(REG_TRIG_SRC, 16'h0002);
      wr(REG_SELECT, 16'h0001);
      rd(REG_STATUS);
      chk(q & 16'h0007, 16'h0002);
      chk(rf_out.on, 1'b0);
      chk(seq_running, 1'b1);
      poll(REG_STATUS, 16'h0007, 16'h0003);
      chk(rf_out.freq, 16'h2000);
      chk(rf_out.on, 1'b1);
      wr(REG_PRECOMPILE, 16'h0001);
      poll(REG_PRECOMPILE, 16'hffff, 16'h0002);
      rd(REG_CLEAR);
      chk(q, 16'h000a);
      rd(REG_STATUS);
      chk(q & 16'h0020, 16'h0000);
      $display("test pause done");
   endtask
   task automatic test_power();
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      #1 chk(rf_out.on, 1'b0);
      chk(seq_running, 1'b0);
      rd(REG_TRIG_SRC);
      chk(q, 16'h0002);
      rd(REG_CLEAR);
      chk(q, 16'h0000);
      rd(REG_APPEND);
      chk(q, 16'h0002);
      wr(REG_CLEAR, 16'h0001);
      rd(REG_APPEND);
      chk(q, 16'h0000);
      $display("test power done");
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         complete_run();
      end
   end
   initial begin
      reset_n = 1'b0;
      nv_init_n = 1'b0;
      bus_req = '0;
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      nv_init_n <= 1'b1;
      test_codes();
      test_precompile();
      test_step();
      test_cont();
      test_sweep();
      test_pause();
      test_power();
      complete_run();
   end
endmodule
